//--- hdl/rcv_core.sv
// Reset configuration sequencer and interrupt vectoring for the CPU core.
// Assumes a flash controller answering one option-byte read and a config load done flag.
`timescale 1ns/1ps
module rcv_core (
   input wire logic clock_i,
   input wire logic sys_rst_i,
   input wire logic [rcv_pkg::RCV_NSRC-1:0] src_pending_i,
   input wire logic [rcv_pkg::RCV_NSRC-1:0] src_local_en_i,
   input wire logic i_mask_i,
   input wire logic x_mask_i,
   input wire logic stop_mode_i,
   input wire logic wait_mode_i,
   input wire logic base_wr_i,
   input wire logic [7:0] base_data_i,
   input wire logic flash_busy_i,
   input wire logic opt_rdy_i,
   input wire logic [7:0] opt_data_i,
   input wire logic cfg_done_i,
   input wire logic cfg_dbl_fault_i,
   output logic [17:0] opt_addr_o,
   output logic opt_req_o,
   output logic flash_abort_o,
   output logic cpu_hold_o,
   output logic secure_o,
   output logic [7:0] vector_base_o,
   output logic [7:0] option_o,
   output rcv_pkg::rcv_wdog_type wdog_init_o,
   output logic wdog_load_o,
   output rcv_pkg::rcv_vector_type vector_o,
   output logic wake_o
);
   import rcv_pkg::*;

   // ----------------------------------------------------------------------
   // State
   // ----------------------------------------------------------------------
   typedef struct packed {
      rcv_state_type state;
      logic [7:0] base;
      logic [7:0] option;
      rcv_wdog_type wdog;
      logic wdog_load;
      logic secure;
      rcv_vector_type vec;
      logic wake;
   } rcv_regs_type;

   rcv_regs_type r_ff;
   rcv_regs_type nxt_r;
   logic [RCV_NSRC-1:0] req;
   logic [RCV_NSRC-1:0] gated;
   logic hit;
   logic [3:0] idx;

   function automatic logic [7:0] slot_offset(input logic [3:0] s);
      case (s)
         4'h0: slot_offset = OFS_TRAP;
         4'h1: slot_offset = OFS_SWTRAP;
         4'h2: slot_offset = OFS_DLERR;
         4'h3: slot_offset = OFS_DLEXT;
         4'h4: slot_offset = OFS_TICK;
         4'h5: slot_offset = OFS_SPI;
         4'h6: slot_offset = OFS_OSC;
         4'h7: slot_offset = OFS_PLL;
         4'h8: slot_offset = OFS_FERR;
         4'h9: slot_offset = OFS_FCMD;
         4'hA: slot_offset = OFS_LVW;
         default: slot_offset = OFS_SPUR;
      endcase
   endfunction : slot_offset

   // ----------------------------------------------------------------------
   // Masking
   // ----------------------------------------------------------------------
   // Unmaskable sources need no local enable; all others need theirs.
   assign gated = src_pending_i & (src_local_en_i | UNMASKABLE_SET);
   always_comb begin
      for (int i = 0; i < RCV_NSRC; i++) begin
         if (UNMASKABLE_SET[i]) begin
            req[i] = gated[i];
         end else if (HIPRI_MASK_SET[i]) begin
            req[i] = gated[i] & ~x_mask_i;
         end else begin
            req[i] = gated[i] & ~i_mask_i;
         end
      end
   end

   rcv_prio u_prio (
      .req_i(req),
      .hit_o(hit),
      .idx_o(idx)
   );

   // ----------------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------------
   always_comb begin
      nxt_r = r_ff;
      nxt_r.wdog_load = 1'b0;
      case (r_ff.state)
         ST_ABORT: begin
            if (!flash_busy_i) begin
               nxt_r.state = ST_FETCH;
            end
         end
         ST_FETCH: begin
            if (opt_rdy_i) begin
               nxt_r.option = opt_data_i;
               nxt_r.wdog.rate = ~opt_data_i[2:0];
               nxt_r.wdog.window = ~opt_data_i[OPT_WIN_BIT];
               nxt_r.wdog_load = 1'b1;
               nxt_r.state = ST_WAIT;
            end
         end
         ST_WAIT: begin
            if (cfg_dbl_fault_i) begin
               nxt_r.secure = 1'b1;
            end
            if (cfg_done_i) begin
               nxt_r.state = ST_RUN;
            end
         end
         ST_RUN: begin
            if (base_wr_i) begin
               nxt_r.base = base_data_i;
            end
         end
         default: nxt_r.state = ST_ABORT;
      endcase
      nxt_r.vec.valid = hit && (r_ff.state == ST_RUN);
      nxt_r.vec.source = idx;
      nxt_r.vec.address = {r_ff.base, slot_offset(idx)};
      nxt_r.wake = (stop_mode_i && |(req & STOP_WAKE_SET))
                   || (wait_mode_i && |(req & WAIT_WAKE_SET));
   end

   // No RAM is touched here; reset affects only this block's own flops.
   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         r_ff <= '{state: ST_ABORT, base: VECTOR_BASE_RESET, option: OPTION_RESET_VALUE,
                   wdog: '{rate: RATE_RESET_VALUE, window: 1'b0}, wdog_load: 1'b0,
                   secure: 1'b0, vec: '0, wake: 1'b0};
      end else begin
         r_ff <= nxt_r;
      end
   end

   // ----------------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------------
   assign flash_abort_o = sys_rst_i || (r_ff.state == ST_ABORT);
   assign cpu_hold_o = sys_rst_i || (r_ff.state != ST_RUN);
   assign opt_req_o = (r_ff.state == ST_FETCH);
   assign opt_addr_o = OPTION_BYTE_ADDR;
   assign secure_o = r_ff.secure;
   assign vector_base_o = r_ff.base;
   assign option_o = r_ff.option;
   assign wdog_init_o = r_ff.wdog;
   assign wdog_load_o = r_ff.wdog_load;
   assign vector_o = r_ff.vec;
   assign wake_o = r_ff.wake;

endmodule : rcv_core

//--- shared/rcv_pkg.sv
// Constants and carrier types for the reset configuration and vectoring block.
// Assumes one 40 MHz system clock and an active-high asynchronous chip reset.
// What this block does
// - Among pending unmasked sources, grant the one at the highest slot offset.
// - Vector address equals programmable vector base plus the source's fixed offset.
// - Each slot holds one 16-bit address; each slot is two bytes wide.
// - Slot offsets F8,F6,F4,F2,F0,D8,C8,C6,BA,B8,8A,80 as listed per source.
// - After every reset, stall the CPU until flash configuration has loaded.
// - Double-bit faults during configuration load may leave protection and security on.
// - Reset during flash program or erase aborts that operation immediately.
// - Reset never clears or initialises the RAM arrays.
// - Watchdog rate and window bit load from flash option register during reset.
// - Flash option register fills from the configuration byte at 0x3_FF0E.
// - Initial watchdog rate is the bitwise inverse of the low three option bits.
// - Initial window-mode bit is the inverse of option bit 3.
package rcv_pkg;

   // ----------------------------------------------------------------------
   // Source indices, highest priority first
   // ----------------------------------------------------------------------
   localparam int RCV_NSRC = 12;
   localparam int SRC_TRAP = 0;
   localparam int SRC_SWTRAP = 1;
   localparam int SRC_DLERR = 2;
   localparam int SRC_DLEXT = 3;
   localparam int SRC_TICK = 4;
   localparam int SRC_SPI = 5;
   localparam int SRC_OSC = 6;
   localparam int SRC_PLL = 7;
   localparam int SRC_FERR = 8;
   localparam int SRC_FCMD = 9;
   localparam int SRC_LVW = 10;
   localparam int SRC_SPUR = 11;

   // ----------------------------------------------------------------------
   // Slot offsets and class masks
   // ----------------------------------------------------------------------
   localparam logic [7:0] OFS_TRAP = 8'hF8;
   localparam logic [7:0] OFS_SWTRAP = 8'hF6;
   localparam logic [7:0] OFS_DLERR = 8'hF4;
   localparam logic [7:0] OFS_DLEXT = 8'hF2;
   localparam logic [7:0] OFS_TICK = 8'hF0;
   localparam logic [7:0] OFS_SPI = 8'hD8;
   localparam logic [7:0] OFS_OSC = 8'hC8;
   localparam logic [7:0] OFS_PLL = 8'hC6;
   localparam logic [7:0] OFS_FERR = 8'hBA;
   localparam logic [7:0] OFS_FCMD = 8'hB8;
   localparam logic [7:0] OFS_LVW = 8'h8A;
   localparam logic [7:0] OFS_SPUR = 8'h80;
   localparam logic [11:0] UNMASKABLE_SET = 12'h803;
   localparam logic [11:0] HIPRI_MASK_SET = 12'h004;
   localparam logic [11:0] STOP_WAKE_SET = 12'h00C;
   localparam logic [11:0] WAIT_WAKE_SET = 12'h62C;

   // ----------------------------------------------------------------------
   // Reset configuration
   // ----------------------------------------------------------------------
   localparam logic [17:0] OPTION_BYTE_ADDR = 18'h3FF0E;
   localparam int OPT_WIN_BIT = 3;
   localparam logic [7:0] OPTION_RESET_VALUE = 8'hFF;
   localparam logic [7:0] VECTOR_BASE_RESET = 8'hFF;
   localparam logic [2:0] RATE_RESET_VALUE = 3'h0;

   typedef enum logic [1:0] {
      ST_ABORT = 2'b00,
      ST_FETCH = 2'b01,
      ST_WAIT = 2'b10,
      ST_RUN = 2'b11
   } rcv_state_type;

   typedef struct packed {
      logic [2:0] rate;
      logic window;
   } rcv_wdog_type;

   typedef struct packed {
      logic valid;
      logic [3:0] source;
      logic [15:0] address;
   } rcv_vector_type;

endpackage : rcv_pkg

//--- hdl/rcv_prio.sv
// Fixed priority picker for the vector sources.
// Assumes pending bits already masked; index 0 is the highest offset.
`timescale 1ns/1ps
module rcv_prio (
   input wire logic [rcv_pkg::RCV_NSRC-1:0] req_i,
   output logic hit_o,
   output logic [3:0] idx_o
);
   import rcv_pkg::*;

   always_comb begin
      hit_o = 1'b0;
      idx_o = 4'h0;
      for (int i = RCV_NSRC - 1; i >= 0; i--) begin
         if (req_i[i]) begin
            hit_o = 1'b1;
            idx_o = 4'(i);
         end
      end
   end

endmodule : rcv_prio

//--- verification/rcv_checker.sv
// Concurrent checks on the reset sequence and vector outputs of rcv_core.
// Assumes rcv_pkg is compiled first; bound into rcv_core below.
`timescale 1ns/1ps
module rcv_checker (
   input wire logic clock_i,
   input wire logic sys_rst_i,
   input wire logic [rcv_pkg::RCV_NSRC-1:0] src_pending_i,
   input wire logic base_wr_i,
   input wire logic flash_busy_i,
   input wire logic opt_rdy_i,
   input wire logic [7:0] opt_data_i,
   input wire logic cfg_done_i,
   input wire logic opt_req_o,
   input wire logic cpu_hold_o,
   input wire logic [7:0] vector_base_o,
   input wire logic [7:0] option_o,
   input wire rcv_pkg::rcv_wdog_type wdog_init_o,
   input wire logic wdog_load_o,
   input wire rcv_pkg::rcv_vector_type vector_o
);
   import rcv_pkg::*;
   localparam logic [7:0] SLOT [12] = '{OFS_TRAP, OFS_SWTRAP, OFS_DLERR, OFS_DLEXT, OFS_TICK, OFS_SPI,
      OFS_OSC, OFS_PLL, OFS_FERR, OFS_FCMD, OFS_LVW, OFS_SPUR};
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (sys_rst_i);
   chk_fetch_idle: assert property ($rose(opt_req_o) |-> !$past(flash_busy_i))
      else $error("fetch while flash busy");
   chk_hold_cfg: assert property ($fell(cpu_hold_o) |-> $past(cfg_done_i))
      else $error("hold released early");
   chk_opt_take: assert property (
      opt_req_o && opt_rdy_i |=> wdog_load_o && option_o == $past(opt_data_i)) else $error("option not taken");
   chk_wdog_inv: assert property (wdog_load_o |-> wdog_init_o == {~option_o[2:0], ~option_o[3]})
      else $error("watchdog init wrong");
   chk_load_once: assert property (wdog_load_o |=> !wdog_load_o)
      else $error("load pulse too long");
   chk_base_lock: assert property (base_wr_i && cpu_hold_o |=> $stable(vector_base_o))
      else $error("base written outside run");
   chk_slot_map: assert property (
      vector_o.valid |-> vector_o.source < 4'hC && vector_o.address[7:0] == SLOT[vector_o.source])
      else $error("vector slot wrong");
   chk_trap_wins: assert property (
      src_pending_i[0] && !cpu_hold_o |=> vector_o.valid && vector_o.source == 4'h0) else $error("trap not granted");
   chk_base_used: assert property (vector_o.valid |-> vector_o.address[15:8] == $past(vector_base_o))
      else $error("vector base not applied");
   cover property (vector_o.valid && vector_o.source == 4'hB);
   cover property ($fell(cpu_hold_o));
   cover property (base_wr_i && !cpu_hold_o);
endmodule : rcv_checker

bind rcv_core rcv_checker rcv_checker_inst (.*);

//--- verification/rcv_flash_model.sv
// Flash controller stand-in: answers the option byte read, then reports configuration loaded.
// Assumes the requester holds its request level until the answer pulse.
`timescale 1ns/1ps
module rcv_flash_model (
   input wire logic clock_i,
   input wire logic sys_rst_i,
   input wire logic opt_req_i,
   input wire logic [17:0] opt_addr_i,
   input wire logic [7:0] stored_byte_i,
   input wire logic [3:0] lat_i,
   output logic opt_rdy_o,
   output logic [7:0] opt_data_o,
   output logic cfg_done_o
);
   import rcv_pkg::*;
   logic [3:0] cnt;
   logic sent;
   // Outside the answer cycle the data lines show the inverse, never the stored byte.
   assign opt_data_o = opt_rdy_o ? stored_byte_i : ~stored_byte_i;
   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         cnt <= 4'h0;
         sent <= 1'b0;
         opt_rdy_o <= 1'b0;
         cfg_done_o <= 1'b0;
      end else begin
         // A request to any other address is never answered, so the boot hangs and fails.
         opt_rdy_o <= opt_req_i && opt_addr_i == OPTION_BYTE_ADDR && !sent && cnt == lat_i;
         cnt <= opt_req_i ? cnt + 4'h1 : 4'h0;
         sent <= sent | opt_rdy_o;
         cfg_done_o <= sent;
      end
   end
endmodule : rcv_flash_model

//--- verification/tb_top.sv
// Self-checking bench for rcv_core with a flash controller model.
// Assumes rcv_pkg, rcv_prio, rcv_core and the bound checker are compiled first.
`timescale 1ns/1ps
module tb_top;
   import rcv_pkg::*;
   logic clock_i = 0;
   logic sys_rst_i = 1;
   logic [11:0] pend = 0, len = 0;
   logic [3:0] md = 0, lat = 0;
   logic bwr = 0, busy = 1, dbl = 0, rdy, done, req, abrt, hold, sec, lod, wake;
   logic [7:0] bdat = 0, optb = 0, od, vb, ob, eb;
   logic [17:0] oa;
   rcv_wdog_type wd;
   rcv_vector_type vo;
   int num_errors = 0, checked = 0;
   localparam logic [7:0] SLOT [12] = '{OFS_TRAP, OFS_SWTRAP, OFS_DLERR, OFS_DLEXT, OFS_TICK, OFS_SPI,
      OFS_OSC, OFS_PLL, OFS_FERR, OFS_FCMD, OFS_LVW, OFS_SPUR};
   always #12.5 clock_i = ~clock_i;
   rcv_flash_model rcv_flash_model_inst (.clock_i, .sys_rst_i, .opt_req_i(req), .opt_addr_i(oa), .stored_byte_i(optb),
      .lat_i(lat), .opt_rdy_o(rdy), .opt_data_o(od), .cfg_done_o(done));
   rcv_core rcv_core_inst (.clock_i, .sys_rst_i, .src_pending_i(pend), .src_local_en_i(len), .i_mask_i(md[3]),
      .x_mask_i(md[2]), .stop_mode_i(md[1]), .wait_mode_i(md[0]), .base_wr_i(bwr), .base_data_i(bdat),
      .flash_busy_i(busy), .opt_rdy_i(rdy), .opt_data_i(od), .cfg_done_i(done), .cfg_dbl_fault_i(dbl),
      .opt_addr_o(oa), .opt_req_o(req), .flash_abort_o(abrt), .cpu_hold_o(hold), .secure_o(sec),
      .vector_base_o(vb), .option_o(ob), .wdog_init_o(wd), .wdog_load_o(lod), .vector_o(vo), .wake_o(wake));
   task automatic chk(input string n, input logic [23:0] e, s);
      checked++;
      if (s !== e) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task automatic wrap_up;
      $display("errors %0d checks %0d", num_errors, checked);
      if (num_errors == 0 && checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : wrap_up
   // A refused base write is held through reset and the abort state.
   task automatic boot(input logic [7:0] v, input logic f, input int bc);
      @(posedge clock_i);
      sys_rst_i <= 1;
      optb <= v;
      dbl <= f;
      busy <= 1;
      bwr <= 1;
      bdat <= 8'h5A;
      lat <= 4'(bc);
      eb = 8'hFF;
      repeat (5) @(posedge clock_i);
      #1 chk("abort in reset", 3'b110, {abrt, hold, req});
      @(posedge clock_i);
      sys_rst_i <= 0;
      repeat (bc) @(posedge clock_i);
      #1 chk("abort", 2'b10, {abrt, req});
      chk("option address", OPTION_BYTE_ADDR, oa);
      @(posedge clock_i);
      busy <= 0;
      bwr <= 0;
      for (int i = 0; i < 40 && hold !== 0; i++) begin
         @(posedge clock_i);
         #1;
      end
      chk("boot", {1'b0, f, eb, v, ~v[2:0], ~v[3]}, {hold, sec, vb, ob, wd});
   endtask : boot
   task automatic vec(input logic [11:0] p, e, input logic [3:0] m, input logic [5:0] x);
      @(posedge clock_i);
      pend <= p;
      len <= e;
      md <= m;
      @(posedge clock_i);
      #1 chk("valid wake", x[5:4], {vo.valid, wake});
      if (x[5]) chk("vector", {x[3:0], eb, SLOT[x[3:0]]}, {vo.source, vo.address});
   endtask : vec
   initial begin
      boot(8'h00, 0, 0);
      boot(8'h0F, 1, 3);
      for (int i = 0; i < 12; i++) vec(12'h1 << i, 12'hFFF, 0, {2'b10, 4'(i)});
      vec(12'hFFF, 12'hFFF, 0, 6'h20);
      vec(12'hFFC, 12'hFFF, 0, 6'h22);
      vec(12'h7FC, 12'hFFF, 4'h8, 6'h22);
      vec(12'hFF8, 12'hFFF, 4'h8, 6'h2B);
      vec(12'h7FC, 12'hFFF, 4'hC, 6'h00);
      vec(12'h803, 12'h000, 0, 6'h20);
      vec(12'h7F8, 12'h000, 0, 6'h00);
      vec(12'h008, 12'hFFF, 4'h2, 6'h33);
      vec(12'h020, 12'hFFF, 4'h2, 6'h25);
      vec(12'h020, 12'hFFF, 4'h1, 6'h35);
      vec(12'h040, 12'hFFF, 4'h1, 6'h26);
      @(posedge clock_i);
      bwr <= 1;
      bdat <= 8'h3C;
      @(posedge clock_i);
      bwr <= 0;
      eb = 8'h3C;
      vec(12'h010, 12'hFFF, 0, 6'h24);
      boot(8'h08, 0, 1);
      boot(8'hF3, 0, 0);
      wrap_up();
   end
   initial begin
      repeat (2000) @(posedge clock_i);
      num_errors++;
      wrap_up();
   end
endmodule : tb_top
